//--- core/sspd_port.sv
// Serial register port and power-down control of the motion sensor.
// Assumes the host drives the serial clock and is the only initiator;
// the serial clock and data input are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "sspd_consts.svh"
module sspd_port
   import sspd_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = `SSPD_TIMEOUT_CYC,
   parameter int unsigned N_REGS      = 8
) (
   // Clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   // Serial link pins
   input  wire logic i_sck,
   input  wire logic i_sdio,
   output logic      o_sdio,
   output logic      o_sdio_oe_n,
   // Shutter LED pin
   output logic      o_shutter_led_drive,
   output logic      o_shutter_led_oe_n,
   // Status
   output logic      o_power_down,
   output logic      o_analog_en
);
   logic sck_lvl, sck_rise, sck_fall;
   logic sdio_lvl;
   logic tmo;

   sspd_sync u_sck (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_async   (i_sck),
      .o_level   (sck_lvl),
      .o_rise    (sck_rise),
      .o_fall    (sck_fall)
   );

   sspd_sync u_sdio (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_async   (i_sdio),
      .o_level   (sdio_lvl),
      .o_rise    (),
      .o_fall    ()
   );

   // Port state
   sspd_state_t state_r, state_nxt;
   logic [4:0]  edges_r, edges_nxt;
   logic [7:0]  shift_r, shift_nxt;
   logic [6:0]  addr_r, addr_nxt;
   logic [7:0]  cfg_r, cfg_nxt;
   logic        pd_r, pd_nxt;
   logic        drv_r, drv_nxt;
   logic        dout_r, dout_nxt;
   logic        hold_r, hold_nxt;
   logic        tclr;
   logic [7:0]  regs_r [N_REGS];
   logic [7:0]  rd_byte;

   // Address zero is the configuration register; others read as zero
   function automatic logic [7:0] read_reg(input logic [6:0] a,
                                           input logic [7:0] cfg);
      if (a == `SSPD_ADDR_CFG)
         read_reg = cfg;
      else
         read_reg = 8'h00;
   endfunction

   sspd_timer #(
      .LIMIT (TIMEOUT_CYC)
   ) u_timer (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_clear   (tclr),
      .i_run     (state_r != SSPD_IDLE && !pd_r),
      .o_expired (tmo)
   );

   // Read data byte taken from the addressed register
   assign rd_byte = read_reg(addr_r, cfg_r);

   always_comb begin
      state_nxt = state_r;
      edges_nxt = edges_r;
      shift_nxt = shift_r;
      addr_nxt  = addr_r;
      cfg_nxt   = cfg_r;
      pd_nxt    = pd_r;
      drv_nxt   = drv_r;
      dout_nxt  = dout_r;
      hold_nxt  = hold_r;
      tclr      = 1'b0;

      // Final data bit stays on the line until the next falling edge
      if (hold_r && sck_fall) begin
         drv_nxt  = 1'b0;
         hold_nxt = 1'b0;
      end

      if (tmo && !pd_r) begin
         // Slow transaction: drop back to waiting for an address byte
         state_nxt = SSPD_IDLE;
         edges_nxt = 5'h00;
         drv_nxt   = 1'b0;
         hold_nxt  = 1'b0;
         tclr      = 1'b1;
      end else if (sck_rise) begin
         // Sample on rising edges, most significant bit first
         shift_nxt = {shift_r[6:0], sdio_lvl};
         edges_nxt = edges_r + 5'h01;
         case (state_r)
            SSPD_IDLE: begin
               tclr      = 1'b1;
               drv_nxt   = 1'b0;
               hold_nxt  = 1'b0;
               edges_nxt = 5'h01;
               state_nxt = SSPD_ADDR;
            end
            SSPD_ADDR: begin
               if (edges_r + 5'h01 == `SSPD_LAST_ADDR_EDGE) begin
                  addr_nxt = shift_nxt[6:0];
                  if (shift_nxt[7])
                     state_nxt = SSPD_WDATA;
                  else
                     state_nxt = SSPD_RDATA;
               end
            end
            SSPD_WDATA: begin
               if (edges_r + 5'h01 == `SSPD_EDGES_PER_XFER) begin
                  state_nxt = SSPD_IDLE;
                  edges_nxt = 5'h00;
                  if (addr_r == `SSPD_ADDR_CFG) begin
                     if (pd_r)
                        cfg_nxt[`SSPD_CFG_PD_BIT] = shift_nxt[`SSPD_CFG_PD_BIT];
                     else
                        cfg_nxt = shift_nxt;
                     pd_nxt = shift_nxt[`SSPD_CFG_PD_BIT];
                     // Any power-down write leaves the pin released
                     if (shift_nxt[`SSPD_CFG_PD_BIT]) begin
                        drv_nxt  = 1'b0;
                        hold_nxt = 1'b0;
                     end
                  end
                  // Write leaves the pin an input
                  drv_nxt = 1'b0;
               end
            end
            SSPD_RDATA: begin
               if (edges_r + 5'h01 == `SSPD_EDGES_PER_XFER) begin
                  state_nxt = SSPD_IDLE;
                  edges_nxt = 5'h00;
                  hold_nxt  = 1'b1;
               end
            end
            default: begin
               state_nxt = SSPD_IDLE;
               edges_nxt = 5'h00;
            end
         endcase
      end else if (sck_fall && state_r == SSPD_RDATA) begin
         // Device drives its data on falling edges, MSB first
         drv_nxt  = 1'b1;
         dout_nxt = rd_byte[3'(5'd15 - edges_r)];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= SSPD_IDLE;
         edges_r <= 5'h00;
         shift_r <= 8'h00;
         addr_r  <= 7'h00;
         cfg_r   <= `SSPD_CFG_RESET;
         pd_r    <= 1'b0;
         drv_r   <= 1'b0;
         dout_r  <= 1'b0;
         hold_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         edges_r <= edges_nxt;
         shift_r <= shift_nxt;
         addr_r  <= addr_nxt;
         cfg_r   <= cfg_nxt;
         pd_r    <= pd_nxt;
         drv_r   <= drv_nxt;
         dout_r  <= dout_nxt;
         hold_r  <= hold_nxt;
      end
   end

   // Other registers hold their values; power-down gates the analog enable, both pins and the timer, not registers
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < N_REGS; i++)
            regs_r[i] <= 8'h00;
      end else begin
         regs_r[0] <= cfg_r;
      end
   end

   // Shutter LED: a simple strobe from a divider, released when powered down
   logic [15:0] div_r, div_nxt;
   logic        led_r, led_nxt;
   logic        sdo_r, sdo_oe_n_r, led_oe_n_r, pdo_r, ana_r;

   always_comb begin
      div_nxt = div_r + 16'h0001;
      led_nxt = led_r;
      if (div_r == `SSPD_LED_DIV) begin
         div_nxt = 16'h0000;
         led_nxt = ~led_r;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_r      <= 16'h0000;
         led_r      <= 1'b0;
         sdo_r      <= 1'b0;
         sdo_oe_n_r <= 1'b1;
         led_oe_n_r <= 1'b1;
         pdo_r      <= 1'b0;
         ana_r      <= 1'b0;
      end else begin
         div_r      <= div_nxt;
         led_r      <= led_nxt;
         sdo_r      <= dout_nxt;
         sdo_oe_n_r <= ~(drv_nxt && !pd_nxt);
         led_oe_n_r <= pd_nxt;
         pdo_r      <= pd_nxt;
         ana_r      <= ~pd_nxt;
      end
   end

   assign o_sdio              = sdo_r;
   assign o_sdio_oe_n         = sdo_oe_n_r;
   assign o_shutter_led_drive = led_r;
   assign o_shutter_led_oe_n  = led_oe_n_r;
   assign o_power_down        = pdo_r;
   assign o_analog_en         = ana_r;
endmodule
`default_nettype wire

//--- core/sspd_sync.sv
// Two-flop synchroniser with edge detect on the synchronised level.
// Assumes an asynchronous input and the system clock.
`timescale 1ns/1ps
`default_nettype none
module sspd_sync (
   // Clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   // Async input
   input  wire logic i_async,
   // Synchronised level and edges
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic meta_r, sync_r, prev_r;
   logic meta_nxt, sync_nxt, prev_nxt;
   logic [2:0] arm_r, arm_nxt;

   always_comb begin
      meta_nxt = i_async;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
      arm_nxt  = {arm_r[1:0], 1'b1};
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
         arm_r  <= 3'h0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
         arm_r  <= arm_nxt;
      end
   end

   // Edges wait until the chain holds real pin samples: a pin idling high
   // would otherwise look like a rise right after reset and skew the port
   assign o_level = sync_r;
   assign o_rise  = sync_r & ~prev_r & arm_r[2];
   assign o_fall  = ~sync_r & prev_r & arm_r[2];
endmodule
`default_nettype wire

//--- core/sspd_timer.sv
// Transaction timer: counts while armed, flags expiry once it reaches its limit.
// Assumes the caller clears it at the start of each transaction.
`timescale 1ns/1ps
`default_nettype none
module sspd_timer #(
   parameter int unsigned LIMIT = 32'd9000000
) (
   // Clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   // Control
   input  wire logic i_clear,
   input  wire logic i_run,
   // Status
   output logic      o_expired
);
   logic [31:0] cnt_r, cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (i_clear)
         cnt_nxt = 32'h0000_0000;
      else if (i_run && cnt_r < LIMIT)
         cnt_nxt = cnt_r + 32'h0000_0001;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         cnt_r <= 32'h0000_0000;
      else
         cnt_r <= cnt_nxt;
   end

   assign o_expired = (cnt_r >= LIMIT);
endmodule
`default_nettype wire

//--- inc/sspd_consts.svh
// Constants for the sensor serial port and power-down block.
// Assumes a 100 MHz system clock; included by sspd_port and the test bench.
// Contract
// - Writing config bit 6 enters power-down
// - Clearing config bit 6 leaves power-down
// - Transaction timeout disabled while powered down
// - Powered-down config write changes only bit 6
// - Registers keep contents during power-down
// - Config register sits at address zero
// - Power-down stops analog only, not logic
// - LED drive and data pin released when down
// - Host starts transfers and drives clock
// - Write: direction one, address, data byte
// - Drive on falling, sample on rising edges
// - Read: direction zero, address, device data
// - Final data bit held until next fall
// - Data pin stays input after a write
// - Power-down write forces data pin released
// - Timeout resets port if transaction too slow
`ifndef SSPD_CONSTS_SVH
`define SSPD_CONSTS_SVH

`define SSPD_CLK_MHZ        100
`define SSPD_ADDR_CFG       7'h00
`define SSPD_CFG_PD_BIT     6
`define SSPD_CFG_RESET      8'h00
`define SSPD_EDGES_PER_XFER 5'h10
`define SSPD_LAST_ADDR_EDGE 5'h08
`define SSPD_TIMEOUT_MS     90
`define SSPD_TIMEOUT_CYC    (`SSPD_TIMEOUT_MS * 1000 * `SSPD_CLK_MHZ)
`define SSPD_LED_DIV        16'h0FA0

`endif

//--- inc/sspd_pkg.sv
// Types shared by the serial port and power-down block.
// Assumes nothing beyond the constants header.
package sspd_pkg;
   typedef enum logic [3:0] {
      SSPD_IDLE  = 4'b0001,
      SSPD_ADDR  = 4'b0010,
      SSPD_WDATA = 4'b0100,
      SSPD_RDATA = 4'b1000
   } sspd_state_t;
endpackage

//--- tb/sspd_host_model.sv
// Host side of the two-wire port: makes the serial clock, drives and reads data.
// Assumes the bench resolves the shared data line and feeds it back on i_line.
`timescale 1ns/1ps
`default_nettype none
module sspd_host_model #(
   parameter int unsigned HALF_CYC     = 4,
   parameter int unsigned READ_GAP_CYC = 10000
) (
   input  wire logic i_sys_clk,
   input  wire logic i_line,
   output logic      o_sck,
   output logic      o_sdio,
   output logic      o_sdio_oe_n
);
   // Clock idles high between frames
   initial begin
      o_sck       = 1'b1;
      o_sdio      = 1'b0;
      o_sdio_oe_n = 1'b1;
   end
   task automatic half();
      repeat (HALF_CYC) @(negedge i_sys_clk);
   endtask
   task automatic send(input int n, input logic [7:0] v);
      @(negedge i_sys_clk);
      for (int i = n - 1; i >= 0; i--) begin
         o_sck       = 1'b0;
         o_sdio      = v[i];
         o_sdio_oe_n = 1'b0;
         half();
         o_sck = 1'b1;
         half();
      end
   endtask
   task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
      send(8, {1'b1, a});
      send(8, d);
      o_sdio_oe_n = 1'b1;
   endtask
   task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
      send(8, {1'b0, a});
      o_sdio_oe_n = 1'b1;
      repeat (READ_GAP_CYC) @(negedge i_sys_clk);
      for (int i = 7; i >= 0; i--) begin
         o_sck = 1'b0;
         half();
         o_sck = 1'b1;
         d[i]  = i_line;
         half();
      end
   endtask
endmodule
`default_nettype wire

//--- tb/sspd_port_checker.sv
// Assertions on the serial port pins and power-down status.
// Assumes it is bound into sspd_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sspd_port_checker (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Pins and status
   input wire logic i_sck,
   input wire logic o_sdio,
   input wire logic o_sdio_oe_n,
   input wire logic o_shutter_led_oe_n,
   input wire logic o_power_down,
   input wire logic o_analog_en
);
   logic       sck_r;
   logic [3:0] rise_r, rise_nxt;
   logic [3:0] fall_r, fall_nxt;
   // Cycles since the last raw serial clock edge, saturating
   always_comb begin
      rise_nxt = (i_sck && !sck_r) ? 4'h0 : rise_r + {3'h0, rise_r != 4'hF};
      fall_nxt = (!i_sck && sck_r) ? 4'h0 : fall_r + {3'h0, fall_r != 4'hF};
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sck_r  <= 1'b1;
         rise_r <= 4'hF;
         fall_r <= 4'hF;
      end else begin
         sck_r  <= i_sck;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   a_analog_inverse: assert property ($past(i_rst_n) |-> o_analog_en != o_power_down)
      else $error("analog enable does not mirror power-down");
   a_pd_led_float: assert property (o_power_down && $past(o_power_down) |-> o_shutter_led_oe_n)
      else $error("LED pin driven while powered down");
   a_pd_sdio_float: assert property (o_power_down && $past(o_power_down) |-> o_sdio_oe_n)
      else $error("data pin driven while powered down");
   a_pd_after_rise: assert property ($changed(o_power_down) |-> rise_r <= 4'h7)
      else $error("power-down changed without a serial clock rise");
   a_drive_on_fall: assert property ($fell(o_sdio_oe_n) |-> fall_r <= 4'h7)
      else $error("data pin taken away from a clock fall");
   a_release_fall: assert property ($rose(o_sdio_oe_n) && !o_power_down |-> fall_r <= 4'h7)
      else $error("data pin released away from a clock fall");
   a_data_on_fall: assert property (
      !o_sdio_oe_n && $past(!o_sdio_oe_n) && $changed(o_sdio) |-> fall_r <= 4'h7)
      else $error("read data changed away from a clock fall");
   a_led_awake: assert property (
      !o_power_down && !$past(o_power_down) && !$past(o_power_down, 2)
      && $past(i_rst_n, 2) |-> !o_shutter_led_oe_n)
      else $error("LED pin released while awake");
endmodule
bind sspd_port sspd_port_checker i_chk (
   .i_sys_clk(i_sys_clk),
   .i_rst_n(i_rst_n),
   .i_sck(i_sck),
   .o_sdio(o_sdio),
   .o_sdio_oe_n(o_sdio_oe_n),
   .o_shutter_led_oe_n(o_shutter_led_oe_n),
   .o_power_down(o_power_down),
   .o_analog_en(o_analog_en)
);
`default_nettype wire

//--- tb/test_sspd_port.sv
// Self-checking bench for sspd_port driven through the host model.
// Assumes a 100 MHz system clock and a shortened transaction timeout.
`timescale 1ns/1ps
`default_nettype none
`include "sspd_consts.svh"
module test_sspd_port;
   localparam int unsigned TO_CYC   = 20000;
   localparam int unsigned WAKE_CYC = 500;
   logic       i_sys_clk, i_rst_n, sck, host_d, host_oe_n, line;
   logic       float_r = 1'b0;
   logic       dut_d, dut_oe_n, led, led_oe_n, pd, aen, led_was;
   logic [7:0] rd;
   int         miscompares, samples_checked;
   // Released line shows a toggling pattern, never a stale value
   assign line = !dut_oe_n ? dut_d : !host_oe_n ? host_d : float_r;
   always @(negedge i_sys_clk) float_r <= ~float_r;
   sspd_port #(.TIMEOUT_CYC(TO_CYC)) i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
      .i_sck(sck), .i_sdio(line), .o_sdio(dut_d), .o_sdio_oe_n(dut_oe_n),
      .o_shutter_led_drive(led), .o_shutter_led_oe_n(led_oe_n),
      .o_power_down(pd), .o_analog_en(aen));
   sspd_host_model i_host (.i_sys_clk(i_sys_clk), .i_line(line), .o_sck(sck),
      .o_sdio(host_d), .o_sdio_oe_n(host_oe_n));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      repeat (100000) @(posedge i_sys_clk);
      miscompares++;
      give_verdict();
   end
   initial begin
      i_rst_n = 1'b0;
      repeat (4) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      check("analog_en", {7'h0, aen}, 8'h01);
      i_host.write_reg(7'h00, 8'h15);
      check("sdio_oe_n write", {7'h0, dut_oe_n}, 8'h01);
      i_host.read_reg(7'h00, rd);
      check("cfg read", rd, 8'h15);
      check("final bit held", {7'h0, dut_oe_n}, 8'h00);
      $display("test write_read done");
      i_host.write_reg(7'h05, 8'hFF);
      i_host.read_reg(7'h05, rd);
      check("unmapped read", rd, 8'h00);
      $display("test unmapped done");
      i_host.write_reg(7'h00, 8'h55);
      repeat (32) @(negedge i_sys_clk);
      check("pd on", {7'h0, pd}, 8'h01);
      check("analog_en pd", {7'h0, aen}, 8'h00);
      check("led_oe_n pd", {7'h0, led_oe_n}, 8'h01);
      check("sdio_oe_n pd", {7'h0, dut_oe_n}, 8'h01);
      // Digital logic keeps running while the analog side is off
      led_was = led;
      repeat (`SSPD_LED_DIV + 1) @(negedge i_sys_clk);
      check("led toggles pd", {7'h0, led}, {7'h0, ~led_was});
      i_host.write_reg(7'h00, 8'h6A);
      check("pd kept", {7'h0, pd}, 8'h01);
      i_host.write_reg(7'h00, 8'h2A);
      repeat (WAKE_CYC) @(negedge i_sys_clk);
      check("pd off", {7'h0, pd}, 8'h00);
      i_host.read_reg(7'h00, rd);
      check("cfg after pd", rd, 8'h15);
      $display("test power_down done");
      i_host.send(5, 8'h10);
      repeat (TO_CYC + 2000) @(negedge i_sys_clk);
      i_host.write_reg(7'h00, 8'h33);
      i_host.read_reg(7'h00, rd);
      check("cfg after timeout", rd, 8'h33);
      $display("test timeout done");
      give_verdict();
   end
endmodule
`default_nettype wire
